/* design/asu_pkg.sv */
/*
  Constants, field layout and state types of the serial frame option
  and line error block. Assumes a 25 MHz system clock and a 32-bit
  Avalon-MM register port with word registers at index times four.
*/
// Functional notes
// - Idle bit counting starts after start bit when idle_count_type is 0, else after stop.
// - parity_on puts a parity bit in the character MSB; off means none generated or checked.
// - parity_kind 0 is even, 1 is odd, for generation and checking alike.
// - loop_select 0 is normal; loop with receiver_source 0 feeds transmitter into receiver.
// - loop_select and receiver_source both 1 give single-wire mode from transmit pin.
// - rx_edge_flag sets on falling receive edge, or rising when rx_polarity is 1.
// - Edge, bit-error and break flags clear by writing one; zero leaves them.
// - bit_error_value holds the sampled receive level at a mismatch.
// - With bit-error detection on, a sampled mismatch against transmitted bit sets bit_error_flag.
// - With break detect on, a received break sets break_detect_flag.
// - rx_edge_flag requests an interrupt only with rx_edge_irq_en set.
// - bit_error_flag requests an interrupt only with bit_error_irq_enable set.
// - break_detect_flag requests an interrupt only with break_detect_irq_enable set.
// - bit_error_sample_mode 00 disables bit-error detection.
// - Mode 01 samples the receive input at the ninth tick of each bit.
// - Mode 10 samples the receive input at the thirteenth tick of each bit.
// - break_detect_on switches break detection on or off.
// - Alternate registers are reachable only while alt_map_select is one.
// - Sixteen baud ticks make one bit period.
package asu_pkg;
  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_ALT_FLAGS = 3'h0;
  localparam logic [2:0] IDX_ALT_IRQ = 3'h1;
  localparam logic [2:0] IDX_ALT_FEAT = 3'h2;
  localparam logic [2:0] IDX_FRAME = 3'h2;
  localparam logic [2:0] IDX_CTRL = 3'h3;
  localparam logic [2:0] IDX_DATA = 3'h4;
  localparam logic [2:0] IDX_STAT = 3'h5;
  localparam logic [2:0] IDX_BAUD = 3'h6;
  // Field positions
  localparam int B_LOOP = 7;
  localparam int B_RECEIVER_SOURCE = 5;
  localparam int B_ILT = 2;
  localparam int B_PE = 1;
  localparam int B_PT = 0;
  localparam int B_EDGE = 7;
  localparam int B_BIT_ERROR_VALUE = 2;
  localparam int B_BERR = 1;
  localparam int B_BRK = 0;
  localparam int B_BKDON = 0;
  localparam int B_TXEN = 0;
  localparam int B_RXEN = 1;
  localparam int B_POL = 2;
  localparam int B_ALT_MAP_SELECT = 3;
  localparam int B_TXBUSY = 0;
  localparam int B_RXFULL = 1;
  localparam int B_PERR = 2;
  localparam int B_FERR = 3;
  localparam int B_IDLE = 4;
  // Reset values
  localparam logic [7:0] FRAME_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [2:0] FEAT_RST = 3'h0;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  // Bit error sample modes
  localparam logic [1:0] BEM_OFF = 2'h0;
  localparam logic [1:0] BEM_T9 = 2'h1;
  localparam logic [1:0] BEM_T13 = 2'h2;
  // Tick timing, counted from zero
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_9TH = 4'h8;
  localparam logic [3:0] TICK_13TH = 4'hC;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] IDLE_BITS = 4'hA;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } asu_tx_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } asu_rx_t;

  typedef struct packed {
    logic [7:0] frame;
    logic [3:0] ctrl;
    logic [7:0] ien;
    logic [2:0] feat;
    logic edge_f;
    logic berr_f;
    logic bit_error_value;
    logic brk_f;
    logic [15:0] div;
    logic [15:0] dcnt;
    logic tick;
    asu_tx_t txs;
    logic [3:0] txt;
    logic [2:0] txb;
    logic [7:0] txsh;
    logic txd;
    logic txd_oe_n;
    asu_rx_t rxs;
    logic [3:0] rxt;
    logic [2:0] rxb;
    logic [7:0] rxsh;
    logic [7:0] rxd;
    logic rx_full;
    logic perr;
    logic ferr;
    logic idle_f;
    logic idle_done;
    logic [3:0] icnt;
    logic rx_prev;
    logic waitreq;
    logic [31:0] rdata;
    logic irq;
  } asu_state_t;
endpackage

/* design/asu_core.sv */
/*
  Serial transceiver core with frame options, loop and single-wire
  routing, receive edge, bit error and break detection, behind an
  Avalon-MM slave. Assumes all pins synchronous to clk_sys.
*/
`timescale 1ns/1ps
module asu_core
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Serial pins
  input wire logic rxd_i,
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe_n,
  // Interrupt request
  output logic irq_req
);

  asu_pkg::asu_state_t s;
  asu_pkg::asu_state_t n;

  function automatic logic par_bit(input logic [6:0] d, input logic kind);
    par_bit = (^d) ^ kind;
  endfunction

  function automatic logic sample_hit(input logic [1:0] m, input logic [3:0] t);
    logic hit;
    hit = 1'b0;
    case (m)
      asu_pkg::BEM_T9: hit = (t == asu_pkg::TICK_9TH);
      asu_pkg::BEM_T13: hit = (t == asu_pkg::TICK_13TH);
      default: hit = 1'b0;
    endcase
    sample_hit = hit;
  endfunction

  logic [2:0] idx;
  logic alt_map_select;
  logic req;
  logic wr;
  logic rd;
  logic rx_route;
  logic rx_n;
  logic sample_bit;
  logic clr_edge;
  logic clr_berr;
  logic clr_brk;
  logic clr_idle;
  logic set_edge;
  logic set_berr;
  logic set_brk;
  logic set_idle;
  logic [31:0] rval;
  localparam logic [3:0] IDLE_BITS_C = asu_pkg::IDLE_BITS;

  always_comb
  begin
    n = s;
    idx = avs_address[4:2];
    alt_map_select = s.ctrl[asu_pkg::B_ALT_MAP_SELECT];
    req = avs_read | avs_write;
    wr = avs_write & ~s.waitreq & avs_byteenable[0];
    rd = avs_read & ~s.waitreq;
    clr_edge = 1'b0;
    clr_berr = 1'b0;
    clr_brk = 1'b0;
    clr_idle = 1'b0;
    set_edge = 1'b0;
    set_berr = 1'b0;
    set_brk = 1'b0;
    set_idle = 1'b0;
    sample_bit = 1'b0;
    rval = 32'h0000_0000;

    // Receive path routing
    if (!s.frame[asu_pkg::B_LOOP])
    begin
      rx_route = rxd_i;
    end
    else if (s.frame[asu_pkg::B_RECEIVER_SOURCE])
    begin
      rx_route = txd_i;
    end
    else
    begin
      rx_route = s.txd;
    end
    rx_n = rx_route ^ s.ctrl[asu_pkg::B_POL];
    n.rx_prev = rx_n;
    // Inverted polarity turns a rising edge into a falling one
    set_edge = s.rx_prev & ~rx_n;

    // Baud ticks, divisor clocks apart, sixteen per bit
    n.tick = 1'b0;
    if (s.div == 16'h0000)
    begin
      n.dcnt = 16'h0000;
    end
    else if (s.dcnt >= s.div)
    begin
      n.dcnt = 16'h0001;
      n.tick = 1'b1;
    end
    else
    begin
      n.dcnt = s.dcnt + 16'h0001;
    end

    // Bus handshake: read data latched first, commit a cycle later
    if (req && s.waitreq)
    begin
      n.waitreq = 1'b0;
      case (idx)
        asu_pkg::IDX_ALT_FLAGS:
          if (alt_map_select)
          begin
            rval[asu_pkg::B_EDGE] = s.edge_f;
            rval[asu_pkg::B_BIT_ERROR_VALUE] = s.bit_error_value;
            rval[asu_pkg::B_BERR] = s.berr_f;
            rval[asu_pkg::B_BRK] = s.brk_f;
          end
        asu_pkg::IDX_ALT_IRQ:
          if (alt_map_select)
          begin
            rval[7:0] = s.ien;
          end
        asu_pkg::IDX_FRAME:
          if (alt_map_select)
          begin
            rval[2:0] = s.feat;
          end
          else
          begin
            rval[7:0] = s.frame;
          end
        asu_pkg::IDX_CTRL: rval[3:0] = s.ctrl;
        asu_pkg::IDX_DATA: rval[7:0] = s.rxd;
        asu_pkg::IDX_STAT:
        begin
          rval[asu_pkg::B_TXBUSY] = (s.txs != asu_pkg::TX_IDLE);
          rval[asu_pkg::B_RXFULL] = s.rx_full;
          rval[asu_pkg::B_PERR] = s.perr;
          rval[asu_pkg::B_FERR] = s.ferr;
          rval[asu_pkg::B_IDLE] = s.idle_f;
        end
        asu_pkg::IDX_BAUD: rval[15:0] = s.div;
        default: rval = 32'h0000_0000;
      endcase
      n.rdata = rval;
    end
    else if (req)
    begin
      n.waitreq = 1'b1;
    end

    if (rd && idx == asu_pkg::IDX_DATA)
    begin
      n.rx_full = 1'b0;
    end

    if (wr)
    begin
      case (idx)
        asu_pkg::IDX_ALT_FLAGS:
          if (alt_map_select)
          begin
            clr_edge = avs_writedata[asu_pkg::B_EDGE];
            clr_berr = avs_writedata[asu_pkg::B_BERR];
            clr_brk = avs_writedata[asu_pkg::B_BRK];
          end
        asu_pkg::IDX_ALT_IRQ:
          if (alt_map_select)
          begin
            n.ien = avs_writedata[7:0] & 8'h83;
          end
        asu_pkg::IDX_FRAME:
          if (alt_map_select)
          begin
            n.feat = avs_writedata[2:0];
          end
          else
          begin
            n.frame = avs_writedata[7:0] & 8'hA7;
          end
        asu_pkg::IDX_CTRL: n.ctrl = avs_writedata[3:0];
        asu_pkg::IDX_DATA:
          if (s.ctrl[asu_pkg::B_TXEN] && s.txs == asu_pkg::TX_IDLE)
          begin
            n.txs = asu_pkg::TX_START;
            n.txt = 4'h0;
            n.txsh = avs_writedata[7:0];
            if (s.frame[asu_pkg::B_PE])
            begin
              n.txsh[7] = par_bit(avs_writedata[6:0], s.frame[asu_pkg::B_PT]);
            end
          end
        asu_pkg::IDX_STAT: clr_idle = avs_writedata[asu_pkg::B_IDLE];
        asu_pkg::IDX_BAUD:
          if (avs_byteenable[1])
          begin
            n.div = avs_writedata[15:0];
          end
          else
          begin
            n.div = {s.div[15:8], avs_writedata[7:0]};
          end
        default: n.div = s.div;
      endcase
    end

    // Transmitter
    if (s.tick && s.txs != asu_pkg::TX_IDLE)
    begin
      n.txt = s.txt + 4'h1;
      if (sample_hit(s.feat[2:1], s.txt) && rx_route != s.txd)
      begin
        set_berr = 1'b1;
        n.bit_error_value = rx_route;
      end
      if (s.txt == asu_pkg::TICK_LAST)
      begin
        case (s.txs)
          asu_pkg::TX_START:
          begin
            n.txs = asu_pkg::TX_DATA;
            n.txb = 3'h0;
          end
          asu_pkg::TX_DATA:
          begin
            n.txsh = {1'b1, s.txsh[7:1]};
            n.txb = s.txb + 3'h1;
            if (s.txb == asu_pkg::LAST_BIT)
            begin
              n.txs = asu_pkg::TX_STOP;
            end
          end
          default: n.txs = asu_pkg::TX_IDLE;
        endcase
      end
    end
    if (!s.ctrl[asu_pkg::B_TXEN] && s.txs == asu_pkg::TX_IDLE)
    begin
      n.txs = asu_pkg::TX_IDLE;
    end
    case (n.txs)
      asu_pkg::TX_START: n.txd = 1'b0;
      asu_pkg::TX_DATA: n.txd = n.txsh[0];
      default: n.txd = 1'b1;
    endcase
    // Single wire releases the shared pin between characters
    if (s.frame[asu_pkg::B_LOOP] && s.frame[asu_pkg::B_RECEIVER_SOURCE])
    begin
      n.txd_oe_n = ~(s.ctrl[asu_pkg::B_TXEN] && n.txs != asu_pkg::TX_IDLE);
    end
    else
    begin
      n.txd_oe_n = ~s.ctrl[asu_pkg::B_TXEN];
    end

    // Receiver, sampling each bit at mid-period
    if (s.tick)
    begin
      n.rxt = s.rxt + 4'h1;
      sample_bit = (s.rxt == asu_pkg::TICK_MID);
    end
    case (s.rxs)
      asu_pkg::RX_IDLE:
        if (s.ctrl[asu_pkg::B_RXEN] && set_edge)
        begin
          n.rxs = asu_pkg::RX_START;
          n.rxt = 4'h0;
          n.icnt = 4'h0;
          n.idle_done = 1'b0;
          sample_bit = 1'b0;
        end
      asu_pkg::RX_START:
        if (sample_bit && rx_n)
        begin
          n.rxs = asu_pkg::RX_IDLE;
        end
        else if (s.tick && s.rxt == asu_pkg::TICK_LAST)
        begin
          n.rxs = asu_pkg::RX_DATA;
          n.rxb = 3'h0;
        end
      asu_pkg::RX_DATA:
        if (sample_bit)
        begin
          n.rxsh = {rx_n, s.rxsh[7:1]};
        end
        else if (s.tick && s.rxt == asu_pkg::TICK_LAST)
        begin
          n.rxb = s.rxb + 3'h1;
          if (s.rxb == asu_pkg::LAST_BIT)
          begin
            n.rxs = asu_pkg::RX_STOP;
          end
        end
      asu_pkg::RX_STOP:
        if (sample_bit)
        begin
          n.rxs = asu_pkg::RX_IDLE;
          n.rxd = s.rxsh;
          n.rx_full = 1'b1;
          n.ferr = ~rx_n;
          n.perr = s.frame[asu_pkg::B_PE] &&
                   (par_bit(s.rxsh[6:0], s.frame[asu_pkg::B_PT]) != s.rxsh[7]);
          // All-zero character with a low stop bit is a break
          set_brk = s.feat[asu_pkg::B_BKDON] && !rx_n && s.rxsh == 8'h00;
        end
      default: n.rxs = asu_pkg::RX_IDLE;
    endcase

    // Idle counting; after-stop mode counts only once back in idle
    if (sample_bit && s.ctrl[asu_pkg::B_RXEN] && s.rxs != asu_pkg::RX_START)
    begin
      if (!rx_n)
      begin
        n.icnt = 4'h0;
      end
      else if (s.rxs == asu_pkg::RX_IDLE || !s.frame[asu_pkg::B_ILT])
      begin
        if (s.icnt != IDLE_BITS_C)
        begin
          n.icnt = s.icnt + 4'h1;
        end
        if (s.icnt + 4'h1 == asu_pkg::IDLE_BITS && !s.idle_done)
        begin
          set_idle = 1'b1;
          n.idle_done = 1'b1;
        end
      end
    end

    // Set wins over a clear in the same cycle
    n.edge_f = (s.edge_f & ~clr_edge) | set_edge;
    n.berr_f = (s.berr_f & ~clr_berr) | set_berr;
    n.brk_f = (s.brk_f & ~clr_brk) | set_brk;
    n.idle_f = (s.idle_f & ~clr_idle) | set_idle;
    n.irq = (n.edge_f & n.ien[asu_pkg::B_EDGE]) |
            (n.berr_f & n.ien[asu_pkg::B_BERR]) |
            (n.brk_f & n.ien[asu_pkg::B_BRK]);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.frame <= asu_pkg::FRAME_RST;
      s.ctrl <= asu_pkg::CTRL_RST;
      s.ien <= asu_pkg::IEN_RST;
      s.feat <= asu_pkg::FEAT_RST;
      s.div <= asu_pkg::BAUD_RST;
      s.txs <= asu_pkg::TX_IDLE;
      s.rxs <= asu_pkg::RX_IDLE;
      s.txd <= 1'b1;
      s.txd_oe_n <= 1'b1;
      s.rx_prev <= 1'b1;
      s.waitreq <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign txd_o = s.txd;
  assign txd_oe_n = s.txd_oe_n;
  assign irq_req = s.irq;

endmodule

/* dv/asu_checker.sv */
/* Port checker for asu_core.
   Assumes word registers at byte address four times the index. */
`timescale 1ns/1ps
module asu_checker
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Line and interrupt
  input wire logic rxd_i,
  input wire logic irq_req
);
  logic [3:0] ctl_q;
  logic [7:0] ien_q;
  logic [7:0] frm_q;
  logic [2:0] idx;
  logic wok;
  logic rok;
  assign idx = avs_address[4:2];
  assign wok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rok = avs_read && !avs_waitrequest;
  // Shadows commit at the same edge as the design's registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctl_q <= 4'h0;
      ien_q <= 8'h00;
      frm_q <= 8'h00;
    end
    else if (wok)
    begin
      if (idx == 3'h3)
        ctl_q <= avs_writedata[3:0];
      if (idx == 3'h1 && ctl_q[3])
        ien_q <= avs_writedata[7:0] & 8'h83;
      if (idx == 3'h2 && !ctl_q[3])
        frm_q <= avs_writedata[7:0] & 8'hA7;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_wait_one_low: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
  a_req_answered: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  a_no_idle_ack: assert property (
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest) else $error("idle answer");
  a_alt_hidden: assert property (
    rok && (idx == 3'h7 || (!ctl_q[3] && idx < 3'h2)) |-> avs_readdata == 32'h0) else $error("hidden read");
  a_ien_read: assert property (
    rok && ctl_q[3] && idx == 3'h1 |-> avs_readdata == {24'h0, ien_q}) else $error("enables read");
  a_frame_read: assert property (
    rok && !ctl_q[3] && idx == 3'h2 |-> avs_readdata == {24'h0, frm_q}) else $error("frame read");
  a_irq_masked: assert property (
    ien_q == 8'h00 && $past(ien_q) == 8'h00 |-> !irq_req) else $error("masked irq");
  a_edge_irq: assert property (
    $fell(rxd_i ^ ctl_q[2]) && $stable(ctl_q[2]) && !frm_q[7] && ien_q[7] |-> ##[1:2] irq_req)
    else $error("edge irq missing");
  c_alt_read: cover property (rok && ctl_q[3]);
  c_irq: cover property ($rose(irq_req));
  c_edge: cover property ($fell(rxd_i) && ien_q[7]);
endmodule

bind asu_core asu_checker i_asu_checker (
  .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd_i(rxd_i), .irq_req(irq_req)
);

/* dv/asu_node.sv */
/* Remote serial node: sends frames, captures frames, or echoes the
   transmit line late. Assumes 16 clocks a bit. */
`timescale 1ns/1ps
module asu_node
(
  // Clock
  input wire logic clk_sys,
  // Serial line
  input wire logic txd_o,
  output logic line_o
);
  logic [1:0] mode = 2'h0;
  int dly = 1;
  logic drv = 1'b1;
  logic [31:0] hist = 32'hFFFFFFFF;
  always @(posedge clk_sys)
    hist <= {hist[30:0], txd_o};
  // Mode 1 is a reflection that lags by dly clocks
  assign line_o = mode == 2'h1 ? hist[dly - 1] : (mode == 2'h2 ? drv : 1'b1);
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    mode <= 2'h2;
    for (int i = 0; i < 10; i++)
    begin
      drv <= f[i];
      repeat (16) @(posedge clk_sys);
    end
    drv <= 1'b1;
  endtask
  task automatic grab(output logic [7:0] d);
    @(negedge txd_o);
    repeat (24) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      d[i] = txd_o;
      repeat (16) @(posedge clk_sys);
    end
  endtask
endmodule

/* dv/tb_asu_core.sv */
/* Random plus corner bench for asu_core with a remote node.
   Assumes divisor 1, so a bit lasts 16 clocks. */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("unexpected %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb_asu_core;
  logic clk_sys;
  logic rst;
  logic [4:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wd;
  logic [31:0] rdat;
  logic wreq;
  logic rxd;
  logic txi;
  logic txo;
  logic oe_n;
  logic irq;
  logic nl;
  logic sw;
  logic f;
  logic [15:0] lf;
  logic [7:0] g;
  logic [31:0] q;
  int error_cnt;
  int n_tests;
  assign rxd = sw ? 1'b1 : nl;
  // Pin pulled up when nobody drives it
  assign txi = !oe_n ? txo : (sw ? nl : 1'b1);
  asu_core i_asu_core (
    .clk_sys(clk_sys), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .rxd_i(rxd), .txd_i(txi), .txd_o(txo), .txd_oe_n(oe_n), .irq_req(irq)
  );
  asu_node i_asu_node (.clk_sys(clk_sys), .txd_o(txo), .line_o(nl));
  always #20 clk_sys = ~clk_sys;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] txexp(input logic [7:0] d, input logic [1:0] p);
    return p[1] ? {^d[6:0] ^ p[0], d[6:0]} : d;
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [2:0] i, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    adr <= {i, 2'h0};
    wd <= d;
    rd <= !w;
    wr <= w;
    // No cycle limit here; a hung slave is left to the watchdog
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wreq);
    `CHK("wait edges", 2, n)
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wrt(input logic [2:0] i, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, i, d, r);
  endtask
  task automatic rdc(input logic [2:0] i, input logic [31:0] e, input string nm);
    logic [31:0] r;
    bus(1'b0, i, 32'h0, r);
    `CHK(nm, e, r)
  endtask
  task automatic tx(input logic [7:0] d, input logic c);
    logic [31:0] r;
    fork
      if (c)
        i_asu_node.grab(g);
      wrt(3'h4, {24'h0, d});
    join
    r = 32'h1;
    for (int k = 0; k < 60 && r[0]; k++)
      bus(1'b0, 3'h5, 32'h0, r);
    `CHK("tx done", 1'b0, r[0])
  endtask
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    clk_sys = 1'b0;
    rst = 1'b1;
    adr = 5'h00;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0;
    sw = 1'b0;
    lf = 16'h005B;
    error_cnt = 0;
    n_tests = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdc(3'h2, 32'h0, "frame reset");
    rdc(3'h7, 32'h0, "unmapped");
    wrt(3'h6, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      lf = lfsr(lf);
      wrt(3'h2, {16'h0, lf});
      rdc(3'h2, {24'h0, lf[7:0] & 8'hA7}, "frame");
      wrt(3'h1, 32'hFF);
      rdc(3'h1, 32'h0, "hidden");
      wrt(3'h3, 32'h8);
      wrt(3'h1, {16'h0, lf});
      rdc(3'h1, {24'h0, lf[7:0] & 8'h83}, "enables");
      wrt(3'h2, {16'h0, lf});
      rdc(3'h2, {24'h0, lf[7:0] & 8'h07}, "features");
      wrt(3'h3, 32'h0);
      rdc(3'h2, {24'h0, lf[7:0] & 8'hA7}, "frame kept");
    end
    // Random feature bits would flag bit errors in the frames below
    wrt(3'h3, 32'h8);
    wrt(3'h2, 32'h0);
    $display("test registers done");
    wrt(3'h3, 32'h3);
    for (int p = 0; p < 4; p++)
    begin
      lf = lfsr(lf);
      wrt(3'h2, {30'h0, p[1:0]});
      tx(lf[7:0], 1'b1);
      `CHK("tx char", txexp(lf[7:0], p[1:0]), g)
      `CHK("pin driven", 1'b0, oe_n)
    end
    $display("test parity done");
    wrt(3'h2, 32'h80);
    i_asu_node.drv <= 1'b0;
    i_asu_node.mode <= 2'h2;
    tx(8'hC3, 1'b0);
    rdc(3'h4, 32'hC3, "loop rx");
    i_asu_node.drv <= 1'b1;
    wrt(3'h2, 32'h20);
    i_asu_node.send(8'h3C, 1'b1);
    rdc(3'h4, 32'h3C, "normal rx");
    wrt(3'h2, 32'hA0);
    sw <= 1'b1;
    i_asu_node.send(8'h5A, 1'b1);
    rdc(3'h4, 32'h5A, "single wire rx");
    `CHK("pin released", 1'b1, oe_n)
    sw <= 1'b0;
    wrt(3'h2, 32'h0);
    $display("test routing done");
    for (int b = 0; b < 2; b++)
    begin
      wrt(3'h2, {29'h0, b[0], 2'h0});
      wrt(3'h5, 32'h10);
      i_asu_node.send(8'hFF, 1'b1);
      repeat (20) @(posedge clk_sys);
      // Only a count begun after the start bit has reached ten by now
      rdc(3'h5, {27'h0, !b[0], 4'h2}, "idle flag");
    end
    wrt(3'h2, 32'h0);
    $display("test idle type done");
    wrt(3'h3, 32'hB);
    wrt(3'h1, 32'h81);
    for (int b = 0; b < 2; b++)
    begin
      wrt(3'h2, {31'h0, b[0]});
      wrt(3'h0, 32'h81);
      i_asu_node.send(8'h00, 1'b0);
      rdc(3'h0, b[0] ? 32'h81 : 32'h80, "flags");
      `CHK("irq", 1'b1, irq)
      wrt(3'h0, 32'h0);
      rdc(3'h0, b[0] ? 32'h81 : 32'h80, "flags kept");
    end
    wrt(3'h1, 32'h0);
    @(posedge clk_sys);
    `CHK("irq masked", 1'b0, irq)
    wrt(3'h0, 32'h81);
    rdc(3'h0, 32'h0, "flags cleared");
    // Switching polarity alone looks like an edge, so clear after it
    wrt(3'h3, 32'hD);
    i_asu_node.drv <= 1'b0;
    wrt(3'h0, 32'h81);
    rdc(3'h0, 32'h0, "falling ignored");
    i_asu_node.drv <= 1'b1;
    @(posedge clk_sys);
    rdc(3'h0, 32'h80, "rising edge");
    wrt(3'h3, 32'hB);
    $display("test edge and break done");
    wrt(3'h1, 32'h2);
    for (int m = 0; m < 8; m++)
    begin
      wrt(3'h2, {29'h0, m[1:0], 1'b0});
      wrt(3'h0, 32'h87);
      i_asu_node.dly <= 10;
      i_asu_node.mode <= m[2] ? 2'h0 : 2'h1;
      tx(8'h55, 1'b1);
      bus(1'b0, 3'h0, 32'h0, q);
      f = (m[1:0] == 2'h1) || (m[2] && m[1:0] == 2'h2);
      `CHK("bit error flag", f, q[1])
      `CHK("bit error irq", f, irq)
      if (m[2] && f)
        `CHK("bit error value", 1'b1, q[2])
    end
    $display("test bit error done");
    report_and_stop();
  end
endmodule
